// ===== rtl/can_init_control.sv
// Init-hold, bus-off recovery and error-level flag control for a CAN node
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Select 0: level flag set when either error counter exceeds 96.
// - Select 1: level flag set when either error counter is 128 or more.
// - Init-hold is writable while not bus-off; writes ignored during bus-off.
// - Init-hold stops bus activity once the current frame ends, or at once on an error.
// - Init-hold keeps counters; counter writes only accepted under init-hold.
// - Writing init-hold to 1 always clears the low-power request.
// - With init-hold clear, writes to the first 16 memory bytes are dropped.
// - Bus-off forces init-hold to 0 and starts recovery immediately.
// - Clearing init-hold waits for 11 recessive bits before joining the bus.
// - Recovery: 128 runs of 11, power-up run, idle, init-hold set.
// - A write cannot clear init-hold while a timing byte is 00.
// - Transmit error counter reaching 256 enters bus-off.
// - Select 1: level flag clears when both counters are below 128.
module can_init_control #(
  parameter int MEM_BYTES = can_init_pkg::CAN_MEM_BYTES,
  parameter int RUN_LEN = can_init_pkg::RECESSIVE_RUN,
  parameter int RECOVERY_RUNS = can_init_pkg::RECOVERY_RUNS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [can_init_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic can_rx,
  input wire logic bit_tick,
  input wire logic frame_busy,
  input wire logic error_cond,
  input wire logic tx_err_inc,
  input wire logic tx_err_dec,
  input wire logic rx_err_inc,
  input wire logic rx_err_dec,
  output logic bus_enable,
  output logic init_hold,
  output logic bus_off_flag,
  output logic error_level_flag,
  output logic low_power_request,
  output logic irq
);
  import can_init_pkg::*;

  localparam logic [6:0] RECOVERY_LAST = 7'(RECOVERY_RUNS - 1);
  localparam logic [7:0] MEM_LIMIT = 8'(MEM_BYTES);

  bus_state_e state_r;
  bus_state_e state_nxt;
  logic [6:0] recovery_cnt_r;
  logic [6:0] recovery_cnt_nxt;
  logic init_hold_r;
  logic init_hold_nxt;
  logic level_sel_r;
  logic level_sel_nxt;
  logic low_power_r;
  logic low_power_nxt;
  logic bus_off_r;
  logic bus_off_nxt;
  logic level_flag_r;
  logic level_flag_nxt;
  logic bus_enable_r;
  logic bus_enable_nxt;
  logic [8:0] tx_err_r;
  logic [8:0] tx_err_nxt;
  logic [7:0] rx_err_r;
  logic [7:0] rx_err_nxt;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_status_nxt;
  logic [IRQ_W-1:0] irq_enable_r;
  logic [IRQ_W-1:0] irq_enable_nxt;
  logic [IRQ_W-1:0] irq_events;
  logic irq_r;
  logic irq_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] mem_r [MEM_BYTES];
  logic [7:0] mem_nxt [MEM_BYTES];
  logic rx_meta_r;
  logic rx_sync_r;
  logic run_enable;
  logic run_done;
  logic timing_valid;
  logic mem_hit;
  logic [7:0] mem_idx;
  logic level_cond;

  // Bus pin crosses into the clock domain through two flops
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end
    else
    begin
      rx_meta_r <= can_rx;
      rx_sync_r <= rx_meta_r;
    end
  end

  assign run_enable = (state_r == ST_POWER_UP) ||
    (state_r == ST_RECOVERY) || (state_r == ST_RECOVERY_POWER_UP);

  recessive_run_counter #(
    .RUN_LEN(RUN_LEN)
  ) u_run (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .enable(run_enable),
    .bit_tick(bit_tick),
    .rx_recessive(rx_sync_r),
    .run_done(run_done)
  );

  assign mem_idx = addr[7:0];
  assign mem_hit = addr[MEM_SPACE_BIT] && (mem_idx < MEM_LIMIT);
  assign timing_valid = (mem_r[TIMING0_IDX] != TIMING_INVALID) &&
    (mem_r[TIMING1_IDX] != TIMING_INVALID);

  // Level flag follows the live counters in either mode
  always_comb
  begin
    if (level_sel_r)
    begin
      level_cond = (tx_err_r >= LEVEL_HIGH) ||
        ({1'b0, rx_err_r} >= LEVEL_HIGH);
    end
    else
    begin
      level_cond = (tx_err_r > LEVEL_LOW) ||
        ({1'b0, rx_err_r} > LEVEL_LOW);
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    recovery_cnt_nxt = recovery_cnt_r;
    init_hold_nxt = init_hold_r;
    level_sel_nxt = level_sel_r;
    low_power_nxt = low_power_r;
    bus_off_nxt = bus_off_r;
    bus_enable_nxt = bus_enable_r;
    tx_err_nxt = tx_err_r;
    rx_err_nxt = rx_err_r;
    irq_enable_nxt = irq_enable_r;
    irq_status_nxt = irq_status_r;
    irq_events = '0;
    mem_nxt = mem_r;
    rdata_nxt = 8'h00;
    level_flag_nxt = level_cond;
    if (level_cond && !level_flag_r)
    begin
      irq_events[IRQ_LEVEL] = 1'b1;
    end

    // Counters are frozen while the node is off the bus
    if (!bus_off_r)
    begin
      if (tx_err_inc)
      begin
        tx_err_nxt = (tx_err_r >= BUS_OFF_COUNT - TX_ERR_STEP) ?
          BUS_OFF_COUNT : tx_err_r + TX_ERR_STEP;
      end
      else if (tx_err_dec && tx_err_r != 9'h000)
      begin
        tx_err_nxt = tx_err_r - 9'h001;
      end
      if (rx_err_inc && rx_err_r != RX_ERR_MAX)
      begin
        rx_err_nxt = rx_err_r + RX_ERR_STEP;
      end
      else if (rx_err_dec && rx_err_r != 8'h00)
      begin
        rx_err_nxt = rx_err_r - RX_ERR_STEP;
      end
    end

    if (wr_stb)
    begin
      if (addr == ADDR_CTRL)
      begin
        level_sel_nxt = wdata[CTRL_LEVEL_SEL];
        if (wdata[CTRL_INIT_HOLD])
        begin
          low_power_nxt = 1'b0;
        end
        else
        begin
          low_power_nxt = wdata[CTRL_LOW_POWER];
        end
        if (!bus_off_r)
        begin
          init_hold_nxt = wdata[CTRL_INIT_HOLD] || !timing_valid;
        end
      end
      else if (addr == ADDR_TX_ERR && init_hold_r)
      begin
        tx_err_nxt = {1'b0, wdata};
      end
      else if (addr == ADDR_RX_ERR && init_hold_r)
      begin
        rx_err_nxt = wdata;
      end
      else if (addr == ADDR_IRQ_ENABLE)
      begin
        irq_enable_nxt = wdata[IRQ_W-1:0];
      end
      else if (addr == ADDR_IRQ_CLEAR)
      begin
        irq_status_nxt = irq_status_r & ~wdata[IRQ_W-1:0];
      end
      else if (mem_hit)
      begin
        // Message area stays writable while the node runs
        if (init_hold_r || mem_idx >= PROTECTED_BYTES)
        begin
          mem_nxt[mem_idx[4:0]] = wdata;
        end
      end
    end

    if (rd_stb)
    begin
      if (addr == ADDR_CTRL)
      begin
        rdata_nxt[CTRL_INIT_HOLD] = init_hold_r;
        rdata_nxt[CTRL_LEVEL_SEL] = level_sel_r;
        rdata_nxt[CTRL_LOW_POWER] = low_power_r;
      end
      else if (addr == ADDR_STATUS)
      begin
        rdata_nxt[STAT_BUS_OFF] = bus_off_r;
        rdata_nxt[STAT_LEVEL] = level_flag_r;
        rdata_nxt[STAT_SYNCED] = bus_enable_r;
      end
      else if (addr == ADDR_TX_ERR)
      begin
        // Full count of 256 only exists during bus-off
        rdata_nxt = tx_err_r[8] ? 8'hFF : tx_err_r[7:0];
      end
      else if (addr == ADDR_RX_ERR)
      begin
        rdata_nxt = rx_err_r;
      end
      else if (addr == ADDR_IRQ_STATUS)
      begin
        rdata_nxt[IRQ_W-1:0] = irq_status_r;
      end
      else if (addr == ADDR_IRQ_ENABLE)
      begin
        rdata_nxt[IRQ_W-1:0] = irq_enable_r;
      end
      else if (mem_hit)
      begin
        rdata_nxt = mem_r[mem_idx[4:0]];
      end
    end

    case (state_r)
      ST_HOLD:
      begin
        bus_enable_nxt = 1'b0;
        if (!init_hold_nxt)
        begin
          state_nxt = ST_POWER_UP;
        end
      end
      ST_POWER_UP:
      begin
        if (init_hold_nxt)
        begin
          state_nxt = ST_HOLD;
        end
        else if (run_done)
        begin
          state_nxt = ST_ACTIVE;
          bus_enable_nxt = 1'b1;
        end
      end
      ST_ACTIVE:
      begin
        // Cutting a frame short would corrupt the bus for others
        if (init_hold_r && (!frame_busy || error_cond))
        begin
          state_nxt = ST_HOLD;
          bus_enable_nxt = 1'b0;
        end
      end
      ST_RECOVERY:
      begin
        if (run_done)
        begin
          if (recovery_cnt_r == RECOVERY_LAST)
          begin
            state_nxt = ST_RECOVERY_POWER_UP;
            recovery_cnt_nxt = 7'h00;
          end
          else
          begin
            recovery_cnt_nxt = recovery_cnt_r + 7'h01;
          end
        end
      end
      ST_RECOVERY_POWER_UP:
      begin
        if (run_done)
        begin
          state_nxt = ST_HOLD;
          bus_off_nxt = 1'b0;
          init_hold_nxt = 1'b1;
          tx_err_nxt = 9'h000;
          rx_err_nxt = 8'h00;
          irq_events[IRQ_RECOVERED] = 1'b1;
        end
      end
      default:
      begin
        state_nxt = ST_HOLD;
      end
    endcase

    // Bus-off overrides a software init-hold write in the same cycle
    if (!bus_off_r && tx_err_nxt >= BUS_OFF_COUNT)
    begin
      bus_off_nxt = 1'b1;
      init_hold_nxt = 1'b0;
      state_nxt = ST_RECOVERY;
      recovery_cnt_nxt = 7'h00;
      bus_enable_nxt = 1'b0;
      irq_events[IRQ_BUS_OFF] = 1'b1;
    end

    // Set wins over a clear in the same cycle
    irq_status_nxt = irq_status_nxt | irq_events;
    irq_nxt = |(irq_status_nxt & irq_enable_nxt);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state_r <= ST_HOLD;
      recovery_cnt_r <= 7'h00;
      init_hold_r <= RESET_INIT_HOLD;
      level_sel_r <= 1'b0;
      low_power_r <= 1'b0;
      bus_off_r <= 1'b0;
      level_flag_r <= 1'b0;
      bus_enable_r <= 1'b0;
      tx_err_r <= 9'h000;
      rx_err_r <= 8'h00;
      irq_status_r <= '0;
      irq_enable_r <= '0;
      irq_r <= 1'b0;
      rdata_r <= 8'h00;
      for (int i = 0; i < MEM_BYTES; i++)
      begin
        mem_r[i] <= RESET_BYTE;
      end
    end
    else
    begin
      state_r <= state_nxt;
      recovery_cnt_r <= recovery_cnt_nxt;
      init_hold_r <= init_hold_nxt;
      level_sel_r <= level_sel_nxt;
      low_power_r <= low_power_nxt;
      bus_off_r <= bus_off_nxt;
      level_flag_r <= level_flag_nxt;
      bus_enable_r <= bus_enable_nxt;
      tx_err_r <= tx_err_nxt;
      rx_err_r <= rx_err_nxt;
      irq_status_r <= irq_status_nxt;
      irq_enable_r <= irq_enable_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
      mem_r <= mem_nxt;
    end
  end

  assign rdata = rdata_r;
  assign bus_enable = bus_enable_r;
  assign init_hold = init_hold_r;
  assign bus_off_flag = bus_off_r;
  assign error_level_flag = level_flag_r;
  assign low_power_request = low_power_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// ===== rtl/can_init_pkg.sv
// Shared constants for the CAN init-hold and error-level control block
package can_init_pkg;
  // Register port: addr[8]=0 is control space, addr[8]=1 is CAN memory
  localparam int ADDR_W = 9;
  localparam logic [8:0] ADDR_CTRL = 9'h000;
  localparam logic [8:0] ADDR_STATUS = 9'h001;
  localparam logic [8:0] ADDR_TX_ERR = 9'h002;
  localparam logic [8:0] ADDR_RX_ERR = 9'h003;
  localparam logic [8:0] ADDR_IRQ_STATUS = 9'h004;
  localparam logic [8:0] ADDR_IRQ_ENABLE = 9'h005;
  localparam logic [8:0] ADDR_IRQ_CLEAR = 9'h006;
  localparam int MEM_SPACE_BIT = 8;
  // CAN memory layout
  localparam int CAN_MEM_BYTES = 32;
  localparam logic [7:0] PROTECTED_BYTES = 8'h10;
  localparam int TIMING0_IDX = 4;
  localparam int TIMING1_IDX = 5;
  localparam logic [7:0] TIMING_INVALID = 8'h00;
  // Control register fields
  localparam int CTRL_INIT_HOLD = 0;
  localparam int CTRL_LEVEL_SEL = 1;
  localparam int CTRL_LOW_POWER = 2;
  // Status register fields
  localparam int STAT_BUS_OFF = 7;
  localparam int STAT_LEVEL = 6;
  localparam int STAT_SYNCED = 0;
  // Interrupt status fields
  localparam int IRQ_W = 3;
  localparam int IRQ_BUS_OFF = 0;
  localparam int IRQ_LEVEL = 1;
  localparam int IRQ_RECOVERED = 2;
  // Error counter figures
  localparam logic [8:0] LEVEL_LOW = 9'h060;
  localparam logic [8:0] LEVEL_HIGH = 9'h080;
  localparam logic [8:0] BUS_OFF_COUNT = 9'h100;
  localparam logic [8:0] TX_ERR_STEP = 9'h008;
  localparam logic [7:0] RX_ERR_STEP = 8'h01;
  localparam logic [7:0] RX_ERR_MAX = 8'hFF;
  // Bus sequencing counts: run length in bit times, recovery in runs
  localparam int RECESSIVE_RUN = 11;
  localparam int RECOVERY_RUNS = 128;
  // Reset values
  localparam logic RESET_INIT_HOLD = 1'b1;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_POWER_UP = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_RECOVERY = 3'b011,
    ST_RECOVERY_POWER_UP = 3'b100
  } bus_state_e;
endpackage

// ===== rtl/recessive_run_counter.sv
// Counts consecutive recessive bit times and pulses at each full run
`timescale 1ns/1ps
`default_nettype none
module recessive_run_counter #(
  parameter int RUN_LEN = can_init_pkg::RECESSIVE_RUN
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic bit_tick,
  input wire logic rx_recessive,
  output logic run_done
);
  import can_init_pkg::*;

  localparam logic [4:0] LAST = 5'(RUN_LEN - 1);

  logic [4:0] count_r;
  logic [4:0] count_nxt;
  logic run_done_r;
  logic run_done_nxt;

  always_comb
  begin
    count_nxt = count_r;
    run_done_nxt = 1'b0;
    if (!enable)
    begin
      count_nxt = 5'h00;
    end
    else if (bit_tick)
    begin
      if (!rx_recessive)
      begin
        // A dominant bit breaks the run
        count_nxt = 5'h00;
      end
      else if (count_r == LAST)
      begin
        count_nxt = 5'h00;
        run_done_nxt = 1'b1;
      end
      else
      begin
        count_nxt = count_r + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      count_r <= 5'h00;
      run_done_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      run_done_r <= run_done_nxt;
    end
  end

  assign run_done = run_done_r;
endmodule
`default_nettype wire

// ===== testbench/can_bus_node_model.sv
// Other nodes on the CAN bus: bit sample ticks and the bus level
`timescale 1ns/1ps
`default_nettype none
module can_bus_node_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic ref_clk,
  input wire logic dominant,
  output logic bit_tick,
  output logic can_rx
);
  int div_r = 0;
  initial
  begin
    bit_tick = 1'b0;
    can_rx = 1'b1;
  end
  // Bus pull-up: with nobody driving dominant the wire reads recessive
  always @(posedge ref_clk)
  begin
    div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
    bit_tick <= (div_r == TICK_DIV - 1);
    can_rx <= !dominant;
  end
endmodule
`default_nettype wire

// ===== testbench/can_init_control_sva.sv
// Port-level checks of init-hold, bus-off and bus enable behaviour
`timescale 1ns/1ps
`default_nettype none
module can_init_control_sva
  import can_init_pkg::*;
#(
  parameter int RUN_LEN = can_init_pkg::RECESSIVE_RUN
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [can_init_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic can_rx,
  input wire logic bit_tick,
  input wire logic frame_busy,
  input wire logic error_cond,
  input wire logic tx_err_inc,
  input wire logic bus_enable,
  input wire logic init_hold,
  input wire logic bus_off_flag,
  input wire logic low_power_request
);
  logic [1:0] rx_sync_r;
  int run_r;
  // Own recessive run count; never below the design's, so safe as a floor
  always_ff @(posedge ref_clk)
  begin
    rx_sync_r <= {rx_sync_r[0], can_rx};
    if (!reset_n || (bit_tick && !rx_sync_r[1]))
      run_r <= 0;
    else if (bit_tick && run_r < 255)
      run_r <= run_r + 1;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  a_busoff_drops_hold: assert property (
    $rose(bus_off_flag) |-> !init_hold && !bus_enable)
    else $error("bus-off entered without dropping init-hold");
  a_busoff_hold_low: assert property (
    bus_off_flag |-> !init_hold)
    else $error("init-hold high during bus-off");
  a_hold_stops_bus: assert property (
    init_hold && !frame_busy |=> !bus_enable)
    else $error("bus still enabled under init-hold");
  a_busy_keeps_bus: assert property (
    init_hold && bus_enable && frame_busy && !error_cond && !tx_err_inc
    |=> bus_enable)
    else $error("bus cut in mid-frame");
  a_hold_clears_lp: assert property (
    wr_stb && addr == ADDR_CTRL && wdata[CTRL_INIT_HOLD] && !bus_off_flag
    |=> bus_off_flag || (init_hold && !low_power_request))
    else $error("low-power request survived init-hold write");
  a_recover_sets_hold: assert property (
    $fell(bus_off_flag) |-> init_hold && !bus_enable)
    else $error("recovery end without init-hold");
  a_enable_after_run: assert property (
    $rose(bus_enable) |-> run_r >= RUN_LEN)
    else $error("bus joined before a full recessive run");
  a_off_after_inc: assert property (
    $rose(bus_off_flag) |-> $past(tx_err_inc, 2) || $past(tx_err_inc))
    else $error("bus-off without a transmit error");
  a_enable_not_off: assert property (
    bus_enable |-> !bus_off_flag)
    else $error("bus enabled while bus-off");
endmodule
`default_nettype wire

// ===== testbench/can_init_control_bench.sv
// Self-checking bench for the CAN init-hold and error-level block
`timescale 1ns/1ps
`default_nettype none
module can_init_control_bench;
  import can_init_pkg::*;
  localparam int RUNS = 2;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic frame_busy = 1'b0;
  logic error_cond = 1'b0;
  logic tx_err_inc = 1'b0;
  logic tie_low = 1'b0;
  logic dominant = 1'b0;
  logic [7:0] rdata;
  logic can_rx, bit_tick, bus_enable, init_hold, bus_off_flag;
  logic error_level_flag, low_power_request, irq;
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 33793;
  int m_tx, m_rx, m_sel, m_lp, m_hold, m_off, n, v;
  int t_off;
  int mem [32];
  int tab_a [3] = '{5, 5, 6};
  int tab_d [3] = '{0, 1, 1};
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  can_bus_node_model i_can_bus_node_model (.ref_clk(ref_clk),
    .dominant(dominant), .bit_tick(bit_tick), .can_rx(can_rx));
  can_init_control #(.RECOVERY_RUNS(RUNS)) i_can_init_control (
    .ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .can_rx(can_rx),
    .bit_tick(bit_tick), .frame_busy(frame_busy), .error_cond(error_cond),
    .tx_err_inc(tx_err_inc), .tx_err_dec(tie_low), .rx_err_inc(tie_low),
    .rx_err_dec(tie_low), .bus_enable(bus_enable), .init_hold(init_hold),
    .bus_off_flag(bus_off_flag), .error_level_flag(error_level_flag),
    .low_power_request(low_power_request), .irq(irq));
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    if (a == ADDR_CTRL)
    begin
      m_sel = d[1];
      m_lp = d[0] ? 0 : d[2];
      if (!m_off && (d[0] || (mem[4] != 0 && mem[5] != 0)))
        m_hold = d[0];
    end
    else if (a == ADDR_TX_ERR && m_hold)
      m_tx = d;
    else if (a == ADDR_RX_ERR && m_hold)
      m_rx = d;
    else if (a[8] && (m_hold || a[7:0] >= 16))
      mem[a[4:0]] = d;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic wait_until(input bit off, output int cnt);
    cnt = 0;
    while ((off ? bus_off_flag !== 1'b0 : bus_enable !== 1'b1) && cnt < 1000)
    begin
      @(posedge ref_clk);
      cnt++;
    end
    #1;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    m_hold = 1;
    {m_tx, m_rx, m_sel, m_lp, m_off} = '0;
    foreach (mem[i]) mem[i] = 0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    wr(ADDR_CTRL, 8'h04);
    rd(ADDR_CTRL, 8'(m_lp * 4 + m_hold));
    wr(ADDR_CTRL, 8'h05);
    rd(ADDR_CTRL, 8'(m_lp * 4 + m_hold));
    for (int k = 0; k < 16; k++)
    begin
      v = (k % 4 == 0) ? 96 : (k % 4 == 1) ? 97 : (k % 4 == 2) ? 127 : 128;
      wr(ADDR_TX_ERR, 8'((k & 4) ? xs() % 90 : v));
      wr(ADDR_RX_ERR, 8'((k & 4) ? v : xs() % 90));
      wr(ADDR_CTRL, 8'(1 + (k / 8) * 2));
      rd(ADDR_TX_ERR, 8'(m_tx));
      n = m_sel ? (m_tx >= 128 || m_rx >= 128) : (m_tx > 96 || m_rx > 96);
      rd(ADDR_STATUS, 8'(n * 64));
      check(error_level_flag, 9'(n));
    end
    wr(9'h104, 8'(xs()) | 8'h01);
    wr(9'h105, 8'(xs()) | 8'h01);
    wr(ADDR_TX_ERR, 8'h00);
    wr(ADDR_RX_ERR, 8'h00);
    dominant <= 1'b1;
    wr(ADDR_CTRL, 8'h02);
    #1 check(init_hold, 1'b0);
    wr(9'h104, 8'h00);
    wr(9'h110, 8'(xs()));
    wr(ADDR_TX_ERR, 8'h55);
    rd(9'h104, 8'(mem[4]));
    rd(9'h110, 8'(mem[16]));
    rd(ADDR_TX_ERR, 8'(m_tx));
    check(bus_enable, 1'b0);
    dominant <= 1'b0;
    wait_until(0, n);
    check(n >= 40 && n <= 60, 1'b1);
    frame_busy <= 1'b1;
    wr(ADDR_CTRL, 8'h03);
    repeat (5) @(posedge ref_clk);
    #1 check(bus_enable, 1'b1);
    error_cond <= 1'b1;
    @(posedge ref_clk);
    error_cond <= 1'b0;
    frame_busy <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check(bus_enable, 1'b0);
    wr(ADDR_TX_ERR, 8'hF8);
    wr(ADDR_IRQ_ENABLE, 8'h07);
    wr(ADDR_IRQ_CLEAR, 8'h07);
    wr(ADDR_CTRL, 8'h02);
    wait_until(0, n);
    tx_err_inc <= 1'b1;
    @(posedge ref_clk);
    tx_err_inc <= 1'b0;
    repeat (4) @(posedge ref_clk);
    m_off = 1;
    // Recovery started a few cycles before this mark
    t_off = $time;
    #1 check({bus_off_flag, init_hold, irq}, 3'b101);
    wr(ADDR_CTRL, 8'h03);
    #1 check(init_hold, 1'b0);
    rd(ADDR_IRQ_STATUS, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      wr(9'(tab_a[k]), 8'(tab_d[k]));
      repeat (2) @(posedge ref_clk);
      #1 check(irq, 1'(k == 1));
    end
    wait_until(1, n);
    n = ($time - t_off) / 10;
    check(n >= (RUNS + 1) * RECESSIVE_RUN * 4 - 8, 1'b1);
    check(init_hold, 1'b1);
    {m_off, m_tx, m_rx} = '0;
    m_hold = 1;
    rd(ADDR_TX_ERR, 8'(m_tx));
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h04);
    rd(9'h007, 8'h00);
    report_and_stop();
  end
endmodule
bind can_init_control can_init_control_sva #(.RUN_LEN(RUN_LEN)) chk_init (
  .ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .can_rx(can_rx), .bit_tick(bit_tick),
  .frame_busy(frame_busy), .error_cond(error_cond), .tx_err_inc(tx_err_inc),
  .bus_enable(bus_enable), .init_hold(init_hold),
  .bus_off_flag(bus_off_flag), .low_power_request(low_power_request));
`default_nettype wire
